// ==== iqm_defines.svh ====
/*
  iqm_defines.svh: register offsets, field positions, reset values
  and divider counts of the iq mixer correction path.
  assumes: included by bare name from the design files.
*/
`ifndef IQM_DEFINES_SVH
`define IQM_DEFINES_SVH

// byte register offsets on the serial port
`define IQM_A_RATE  5'h00
`define IQM_A_CLOCK 5'h01
`define IQM_A_MIX   5'h02
`define IQM_A_TUNE3 5'h09
`define IQM_A_TUNE2 5'h0a
`define IQM_A_TUNE1 5'h0b
`define IQM_A_TUNE0 5'h0c
`define IQM_A_PHS1  5'h0d
`define IQM_A_PHS0  5'h0e
`define IQM_A_GA1   5'h10
`define IQM_A_GA0   5'h11
`define IQM_A_GB1   5'h12
`define IQM_A_GB0   5'h13
`define IQM_A_SKW1  5'h14
`define IQM_A_SKW0  5'h15
`define IQM_A_OA1   5'h16
`define IQM_A_OA0   5'h17
`define IQM_A_OB1   5'h18
`define IQM_A_OB0   5'h19
`define IQM_A_FSA1  5'h1a
`define IQM_A_FSA0  5'h1b
`define IQM_A_FSB1  5'h1c
`define IQM_A_FSB0  5'h1d
`define IQM_A_STAT  5'h1f

// field positions
`define IQM_B_GAIN  6
`define IQM_B_FINE_MIXER  4
`define IQM_B_DUAL  0
`define IQM_B_INV   1

// reset values: correction gains at unity (1024)
`define IQM_RST_G1  8'h04

// counts
`define IQM_SIF_LAST 3'h7
`define IQM_DIV_X2   4'h2
`define IQM_DIV_X4   4'h4
`define IQM_DIV_X8   4'h8
`define IQM_UNITY_SH 10

`endif

// ==== iqm_pkg.sv ====
/*
  iqm_pkg: types and small arithmetic helpers of the mixer path.
  assumes: nothing beyond a systemverilog compiler.
*/
package iqm_pkg;
  // serial port byte phase, one-hot
  typedef enum logic [2:0] {
    IQM_SIF_INSTR = 3'b001,
    IQM_SIF_DATA  = 3'b010,
    IQM_SIF_DONE  = 3'b100
  } iqm_sif_t;
  // interpolation mode field
  typedef enum logic [1:0] {
    IQM_X2  = 2'b00,
    IQM_X4  = 2'b01,
    IQM_X4L = 2'b10,
    IQM_X8  = 2'b11
  } iqm_interp_t;
  typedef logic signed [15:0] iqm_smp_t;
  // clamp a wide value to one sample
  function automatic iqm_smp_t iqm_sat(input logic signed [35:0] x);
    if (x > 36'sh0_0000_7fff) begin
      iqm_sat = 16'sh7fff;
    end else if (x < -36'sh0_0000_8000) begin
      iqm_sat = -16'sh8000;
    end else begin
      iqm_sat = x[15:0];
    end
  endfunction
  // negate without wrapping the most negative code
  function automatic iqm_smp_t iqm_neg(input iqm_smp_t x);
    iqm_neg = (x == -16'sh8000) ? 16'sh7fff : -x;
  endfunction
endpackage

// ==== iqm_nco.sv ====
/*
  iqm_nco: 32-bit phase accumulator with sine and cosine lookup.
  assumes: adv_i and strobe_i come from logic on core_clk_i.
*/
`timescale 1ns/1ps
module iqm_nco
  import iqm_pkg::*;
(
  input  wire logic        core_clk_i, // sample clock
  input  wire logic        rstn_i,     // async reset, low
  input  wire logic        adv_i,      // oscillator tick
  input  wire logic        strobe_i,   // phase strobe pulse
  input  wire logic [31:0] tune_i,     // tuning word
  input  wire logic [15:0] phase_i,    // phase offset
  output iqm_smp_t         sin_o,      // sine, q15
  output iqm_smp_t         cos_o       // cosine, q15
);
  typedef struct packed {
    logic [31:0] acc; // phase accumulator
  } iqm_nco_st_t;
  iqm_nco_st_t r;     // registered state
  iqm_nco_st_t n;     // next state
  logic [15:0] ang;   // oscillator angle
  // quarter-wave table, 32 steps per turn
  function automatic iqm_smp_t qsin(input logic [4:0] x);
    logic [3:0] j;
    iqm_smp_t   m;
    j = x[3] ? 4'h8 - {1'h0, x[2:0]} : {1'h0, x[2:0]};
    unique case (j)
      4'h0: m = 16'sh0000;
      4'h1: m = 16'sh18f9;
      4'h2: m = 16'sh30fc;
      4'h3: m = 16'sh471d;
      4'h4: m = 16'sh5a82;
      4'h5: m = 16'sh6a6e;
      4'h6: m = 16'sh7642;
      4'h7: m = 16'sh7d8a;
      default: m = 16'sh7fff; // quarter turn, peak
    endcase
    qsin = x[4] ? -m : m;
  endfunction
  // strobe clears, tick adds, sum wraps modulo 2^32
  always_comb begin
    n = r;
    if (strobe_i) begin
      n.acc = '0;
    end else if (adv_i) begin
      n.acc = r.acc + tune_i;
    end
  end
  // angle: top half of accumulator plus phase offset
  assign ang = r.acc[31:16] + phase_i;
  assign sin_o = qsin(ang[15:11]);
  assign cos_o = qsin(ang[15:11] + 5'h08);
  // state register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_strobe_zero : assert property (
    strobe_i |=> r.acc == 32'h0)
    else $error("strobe did not clear accumulator");
  a_acc_step : assert property (
    adv_i && !strobe_i |=> r.acc == $past(r.acc) + $past(tune_i))
    else $error("accumulator did not add tuning word");
endmodule

// ==== iqm_coarse_mixer.sv ====
/*
  iqm_coarse_mixer: coarse mixer, half or quarter rate sign and swap.
  assumes: one sample per core_clk_i; strobe from the same clock.
*/
`timescale 1ns/1ps
module iqm_coarse_mixer
  import iqm_pkg::*;
(
  input  wire logic       core_clk_i, // sample clock
  input  wire logic       rstn_i,     // async reset, low
  input  wire logic       strobe_i,   // restart sequence
  input  wire logic [3:0] mode_i,     // coarse_mix_select
  input  iqm_smp_t        a_i,        // channel a in
  input  iqm_smp_t        b_i,        // channel b in
  output iqm_smp_t        a_o,        // channel a out
  output iqm_smp_t        b_o         // channel b out
);
  typedef struct packed {
    logic [1:0] cnt; // sample phase in sequence
  } iqm_cm_st_t;
  iqm_cm_st_t r;    // registered state
  iqm_cm_st_t n;    // next state
  logic       na;   // negate channel a
  logic       nb;   // negate channel b
  // step every output sample, strobe restarts at phase 0
  always_comb begin
    n = r;
    n.cnt = strobe_i ? 2'h0 : r.cnt + 2'h1;
  end
  // sign choice per mode and phase; the swap is chosen below
  always_comb begin
    na = 1'b0;
    nb = 1'b0;
    unique case (mode_i[3:2])
      2'b00: begin
        na = 1'b0;
      end
      2'b01: begin
        na = r.cnt[0] ^ ~mode_i[1];
        nb = r.cnt[0] ^ ~mode_i[0];
      end
      2'b10: begin
        na = (r.cnt == 2'h1 || r.cnt == 2'h2) ^ mode_i[1];
        nb = r.cnt[1] ^ mode_i[0];
      end
      2'b11: begin
        na = r.cnt[1] ^ mode_i[1];
        nb = (r.cnt == 2'h1 || r.cnt == 2'h2) ^ mode_i[0];
      end
    endcase
  end
  // quarter-rate modes swap channels on odd phases
  always_comb begin
    if (mode_i[3] && r.cnt[0]) begin
      a_o = na ? iqm_neg(b_i) : b_i;
      b_o = nb ? iqm_neg(a_i) : a_i;
    end else begin
      a_o = na ? iqm_neg(a_i) : a_i;
      b_o = nb ? iqm_neg(b_i) : b_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_pass_mode : assert property (
    mode_i[3:2] == 2'b00 |-> a_o == a_i && b_o == b_i)
    else $error("no-mix mode altered data");
  a_fs4_swap : assert property (
    mode_i == 4'h8 && r.cnt == 2'h1 |-> a_o == iqm_neg(b_i) && b_o == a_i)
    else $error("quarter-rate phase 1 wrong");
  a_fs2_flip : assert property (
    mode_i[3:2] == 2'b01 && $past(mode_i) == mode_i && !$past(strobe_i)
    && $stable(a_i) && a_i != -16'sh8000 |-> a_o == -$past(a_o))
    else $error("half-rate sign did not alternate");
  c_fs4 : cover property (mode_i[3] && r.cnt == 2'h3);
endmodule

// ==== iqm_top.sv ====
/*
  iqm_top: transmit path with fine mixer, quadrature correction,
  offset, coarse mixer, clock mode and data-rate clock output,
  programmed through a four-wire serial register port.
  assumes: core_clk_i is the sample-rate clock; all pins are
  asynchronous and are synchronised here.
*/
// Functional notes
// - tuning word adds to accumulator each tick
// - phase offset sets starting oscillator angle
// - phase strobe clears the accumulator
// - tuning at 09-0c, phase at 0d-0e
// - fine mixer rotates a as i, b as q
// - gain boost bit 6; clear halves result
// - full-rate quad mode: oscillator at sample rate
// - other modes: oscillator at half rate
// - coarse mode 00xx passes data unmixed
// - modes 01xx alternate sign every sample
// - modes 10xx rotate by quarter rate
// - modes 11xx rotate by negative quarter rate
// - coarse mixer runs at output sample rate
// - correction stage limited to 320 msps
// - path gains 11-bit unsigned, zero to two
// - phase skew 10-bit signed, half range
// - path offsets are 13-bit signed
// - offset added after gain, before output
// - full-scale gain: 4-bit step, 8-bit trim
// - pll pin low, dual bit clear: external
// - divide sample clock by ratio, drive out
// - latch on chosen edge of sensed clock
`timescale 1ns/1ps
`include "iqm_defines.svh"
module iqm_top
  import iqm_pkg::*;
(
  input  wire logic        core_clk_i,              // sample clock
  input  wire logic        rstn_i,                  // async reset, low
  input  wire logic        sif_clk_i,               // serial clock
  input  wire logic        sif_en_n_i,              // serial enable, low
  input  wire logic        sif_dio_i,               // serial data in
  output logic             sif_dout_o,              // serial data out
  output logic             sif_dout_oe_o,           // data out enable
  input  wire logic        pll_supply_pin_i,        // pll supply level
  input  wire logic        lock_pin_sense_i,        // lock pin as seen
  input  wire logic        phase_strobe_i,          // phase strobe pin
  input  wire logic [15:0] chan_a_i,                // channel a data
  input  wire logic [15:0] chan_b_i,                // channel b data
  output logic             data_rate_clk_o,         // lock pin drive
  output logic             ext_clk_mode_o,          // external mode
  output logic [15:0]      dac_a_o,                 // channel a out
  output logic [15:0]      dac_b_o,                 // channel b out
  output logic [3:0]       coarse_current_step_a_o, // a coarse step
  output logic [7:0]       fine_current_trim_a_o,   // a fine trim
  output logic [3:0]       coarse_current_step_b_o, // b coarse step
  output logic [7:0]       fine_current_trim_b_o    // b fine trim
);
  // whole module state
  typedef struct packed {
    logic [37:0]      sy1;    // pin sync stage one
    logic [37:0]      sy2;    // pin sync stage two
    logic             sck_d;  // serial clock, one later
    logic             lck_d;  // lock sense, one later
    logic [31:0][7:0] regs;   // byte registers
    iqm_sif_t         sst;    // serial byte phase
    logic [2:0]       bits;   // bit count in byte
    logic [7:0]       sh;     // write shifter
    logic [7:0]       rsh;    // read shifter
    logic [4:0]       addr;   // current address
    logic             rd;     // read transfer
    logic [1:0]       left;   // bytes still to go
    logic             sdo;    // serial out bit
    logic             sdo_oe; // serial out enable
    logic [2:0]       div;    // clock divider count
    logic             dclk;   // data rate clock
    logic             ext;    // external clock mode
    logic             tick;   // half-rate tick
    logic             strb;   // latched strobe pulse
    iqm_smp_t         la;     // latched channel a
    iqm_smp_t         lb;     // latched channel b
    iqm_smp_t         fi;     // fine mixer i
    iqm_smp_t         fq;     // fine mixer q
    iqm_smp_t         qi;     // corrected i
    iqm_smp_t         qq;     // corrected q
    iqm_smp_t         da;     // output a
    iqm_smp_t         db;     // output b
  } iqm_top_st_t;

  iqm_top_st_t r;            // registered state
  iqm_top_st_t n;            // next state
  logic        sck;          // synced serial clock
  logic        en_n;         // synced serial enable
  logic        dio;          // synced serial data
  logic        pll;          // synced pll supply level
  logic        lck;          // synced lock sense
  logic        sck_rise;     // serial clock rising
  logic        sck_fall;     // serial clock falling
  logic        lck_rise;     // lock pin rising
  logic        lck_fall;     // lock pin falling
  logic [7:0]  sbyte;        // byte completing now
  logic        wr_done;      // write byte completes
  logic [7:0]  mix_cfg;      // mixer_config_register
  logic [7:0]  clk_cfg;      // clock_config_register
  iqm_interp_t interp;       // interpolation mode
  logic [3:0]  ratio;        // data clock divide ratio
  logic        adv;          // oscillator tick
  logic [31:0] tune;         // tuning word
  logic [15:0] phs;          // phase offset
  iqm_smp_t    nsin;         // oscillator sine
  iqm_smp_t    ncos;         // oscillator cosine
  iqm_smp_t    cm_a;         // coarse mixer a
  iqm_smp_t    cm_b;         // coarse mixer b
  logic [7:0]  status;       // read-only status byte

  // synced pins and edges
  assign sck = r.sy2[37];
  assign en_n = r.sy2[36];
  assign dio = r.sy2[35];
  assign pll = r.sy2[34];
  assign lck = r.sy2[33];
  assign sck_rise = sck & ~r.sck_d;
  assign sck_fall = ~sck & r.sck_d;
  assign lck_rise = lck & ~r.lck_d;
  assign lck_fall = ~lck & r.lck_d;
  assign sbyte = {r.sh[6:0], dio};
  assign wr_done = !en_n && sck_rise && r.bits == `IQM_SIF_LAST
                   && r.sst == IQM_SIF_DATA && !r.rd;

  // register fields
  assign mix_cfg = r.regs[`IQM_A_MIX];
  assign clk_cfg = r.regs[`IQM_A_CLOCK];
  assign interp = iqm_interp_t'(r.regs[`IQM_A_RATE][1:0]);
  assign tune = {r.regs[`IQM_A_TUNE3], r.regs[`IQM_A_TUNE2],
                 r.regs[`IQM_A_TUNE1], r.regs[`IQM_A_TUNE0]};
  assign phs = {r.regs[`IQM_A_PHS1], r.regs[`IQM_A_PHS0]};
  assign status = {4'h0, r.dclk, lck, r.ext, pll};

  // divide ratio per interpolation mode
  always_comb begin
    unique case (interp)
      IQM_X2:          ratio = `IQM_DIV_X2;
      IQM_X4, IQM_X4L: ratio = `IQM_DIV_X4;
      IQM_X8:          ratio = `IQM_DIV_X8;
    endcase
  end

  // full rate in quad mode, half rate otherwise
  assign adv = (interp == IQM_X4) ? 1'b1 : r.tick;

  // register read value, status is read-only
  function automatic logic [7:0] rdb(input logic [4:0] a);
    rdb = (a == `IQM_A_STAT) ? status : r.regs[a];
  endfunction

  // oscillator
  iqm_nco u_nco (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .adv_i      (adv),
    .strobe_i   (r.strb),
    .tune_i     (tune),
    .phase_i    (phs),
    .sin_o      (nsin),
    .cos_o      (ncos)
  );

  // coarse mixer on corrected samples, once per output sample
  iqm_coarse_mixer u_coarse_mixer (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .strobe_i   (r.strb),
    .mode_i     (mix_cfg[3:0]),
    .a_i        (r.qi),
    .b_i        (r.qq),
    .a_o        (cm_a),
    .b_o        (cm_b)
  );

  // next-state logic for the whole block
  always_comb begin
    logic signed [35:0] mi;
    logic signed [35:0] mq;
    logic signed [35:0] ga;
    logic signed [35:0] gb;
    logic signed [35:0] sk;
    logic signed [35:0] tp;
    mi = '0;
    mq = '0;
    ga = '0;
    gb = '0;
    sk = '0;
    tp = '0;
    n = r;
    // two-flop sync of every pin
    n.sy1 = {sif_clk_i, sif_en_n_i, sif_dio_i, pll_supply_pin_i,
             lock_pin_sense_i, phase_strobe_i, chan_a_i, chan_b_i};
    n.sy2 = r.sy1;
    n.sck_d = sck;
    n.lck_d = lck;

    // serial port: idle while enable is high
    if (en_n) begin
      n.sst = IQM_SIF_INSTR;
      n.bits = 3'h0;
      n.sdo = 1'b0;
      n.sdo_oe = 1'b0;
    end else begin
      // sample data on rising serial clock
      if (sck_rise) begin
        n.sh = sbyte;
        n.bits = r.bits + 3'h1;
        if (r.bits == `IQM_SIF_LAST) begin
          unique case (r.sst)
            // instruction: read flag, byte count, address
            IQM_SIF_INSTR: begin
              n.rd = sbyte[7];
              n.left = sbyte[6:5];
              n.addr = sbyte[4:0];
              n.rsh = rdb(sbyte[4:0]);
              n.sst = IQM_SIF_DATA;
            end
            // data byte: store on write, step address
            IQM_SIF_DATA: begin
              if (!r.rd && r.addr != `IQM_A_STAT) begin
                n.regs[r.addr] = sbyte;
              end
              n.addr = r.addr + 5'h01;
              n.rsh = rdb(r.addr + 5'h01);
              n.left = r.left - 2'h1;
              if (r.left == 2'h0) begin
                n.sst = IQM_SIF_DONE;
              end
            end
            // extra bits after the last byte are ignored
            IQM_SIF_DONE: begin
              n.bits = r.bits + 3'h1;
            end
          endcase
        end
      end
      // read data leaves on falling serial clock
      if (sck_fall && r.rd && r.sst != IQM_SIF_INSTR) begin
        n.sdo_oe = 1'b1;
        n.sdo = (r.sst == IQM_SIF_DONE) ? 1'b0 : r.rsh[7];
        n.rsh = {r.rsh[6:0], 1'b0};
      end
    end

    // clock mode from pll pin and dual-clock bit
    n.ext = !pll && !clk_cfg[`IQM_B_DUAL];

    // data-rate clock: divide sample clock by ratio
    if ({1'b0, r.div} >= ratio - 4'h1) begin
      n.div = 3'h0;
    end else begin
      n.div = r.div + 3'h1;
    end
    n.dclk = n.ext && ({1'b0, n.div} < (ratio >> 1));
    n.tick = ~r.tick;

    // latch data and strobe on the chosen lock pin edge
    n.strb = 1'b0;
    if (r.ext && (clk_cfg[`IQM_B_INV] ? lck_fall : lck_rise)) begin
      n.la = r.sy2[31:16];
      n.lb = r.sy2[15:0];
      n.strb = r.sy2[32];
    end

    // fine mixer: rotate (a, b) by oscillator angle
    mi = 36'(r.la) * 36'(ncos) - 36'(r.lb) * 36'(nsin);
    mq = 36'(r.la) * 36'(nsin) + 36'(r.lb) * 36'(ncos);
    if (!mix_cfg[`IQM_B_FINE_MIXER]) begin
      n.fi = r.la;
      n.fq = r.lb;
    end else if (mix_cfg[`IQM_B_GAIN]) begin
      n.fi = iqm_sat(mi >>> 15);
      n.fq = iqm_sat(mq >>> 15);
    end else begin
      n.fi = iqm_sat(mi >>> 16);
      n.fq = iqm_sat(mq >>> 16);
    end

    // correction: one sample per clock, 320 msps ceiling
    ga = 36'(signed'({1'b0, r.regs[`IQM_A_GA1][2:0],
                      r.regs[`IQM_A_GA0]}));
    gb = 36'(signed'({1'b0, r.regs[`IQM_A_GB1][2:0],
                      r.regs[`IQM_A_GB0]}));
    sk = 36'(signed'({r.regs[`IQM_A_SKW1][1:0],
                      r.regs[`IQM_A_SKW0]}));
    // skew leaks a share of i into q, then path gains
    tp = (36'(r.fi) * sk) >>> `IQM_UNITY_SH;
    mi = (36'(r.fi) * ga) >>> `IQM_UNITY_SH;
    mq = ((36'(r.fq) + tp) * gb) >>> `IQM_UNITY_SH;
    // offsets join after gain, one clamp at the end
    mi = mi + 36'(signed'({r.regs[`IQM_A_OA1][4:0],
                           r.regs[`IQM_A_OA0]}));
    mq = mq + 36'(signed'({r.regs[`IQM_A_OB1][4:0],
                           r.regs[`IQM_A_OB0]}));
    n.qi = iqm_sat(mi);
    n.qq = iqm_sat(mq);

    // coarse mixer result to the converter outputs
    n.da = cm_a;
    n.db = cm_b;
  end

  // state register; gains start at unity
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.sst <= IQM_SIF_INSTR; // serial port starts waiting for a command
      r.regs[`IQM_A_GA1] <= `IQM_RST_G1;
      r.regs[`IQM_A_GB1] <= `IQM_RST_G1;
    end else begin
      r <= n;
    end
  end

  // outputs, all from flops
  assign sif_dout_o = r.sdo;
  assign sif_dout_oe_o = r.sdo_oe;
  assign data_rate_clk_o = r.dclk;
  assign ext_clk_mode_o = r.ext;
  assign dac_a_o = r.da;
  assign dac_b_o = r.db;
  assign coarse_current_step_a_o = r.regs[`IQM_A_FSA1][3:0];
  assign fine_current_trim_a_o = r.regs[`IQM_A_FSA0];
  assign coarse_current_step_b_o = r.regs[`IQM_A_FSB1][3:0];
  assign fine_current_trim_b_o = r.regs[`IQM_A_FSB0];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_ext_mode_sel : assert property (
    !pll && !clk_cfg[`IQM_B_DUAL] |=> ext_clk_mode_o)
    else $error("external clock mode not selected");
  a_dclk_half : assert property (
    r.ext && interp == IQM_X2 && $rose(data_rate_clk_o)
    ##1 r.ext && interp == IQM_X2 |-> !data_rate_clk_o)
    else $error("data clock not divided by two");
  a_latch_rise : assert property (
    r.ext && !clk_cfg[`IQM_B_INV] && lck_rise
    |=> r.la == $past(r.sy2[31:16]) && r.lb == $past(r.sy2[15:0]))
    else $error("data not latched on rising lock edge");
  a_tune_write : assert property (
    wr_done && r.addr == `IQM_A_TUNE0 |=> tune[7:0] == $past(sbyte))
    else $error("tuning byte not stored");
  a_off_pass : assert property (
    r.regs[`IQM_A_GA1] == 8'h04 && r.regs[`IQM_A_GA0] == 8'h00
    && r.regs[`IQM_A_OA1] == 8'h1f && r.regs[`IQM_A_OA0] == 8'hf0
    && r.fi == 16'sh0100 |=> r.qi == 16'sh00f0)
    else $error("offset not added after unity gain");

  c_sif_read : cover property (sck_fall && r.rd && r.sst == IQM_SIF_DATA);
  c_strobe : cover property (r.strb);
  c_boost : cover property (mix_cfg[`IQM_B_GAIN] && mix_cfg[`IQM_B_FINE_MIXER]);
endmodule

// ==== iqm_src_model.sv ====
/*
  iqm_src_model: data source that feeds i/q samples to the path.
  assumes: dclk_i is the data-rate clock from the lock pin and the
  path latches on its rising edge.
*/
`timescale 1ns/1ps
module iqm_src_model (
  input  wire logic        dclk_i,    // data-rate clock
  input  wire logic        stb_req_i, // strobe request
  input  wire logic [15:0] a_val_i,   // i sample value
  input  wire logic [15:0] b_val_i,   // q sample value
  output logic             strobe_o,  // phase strobe pin
  output logic [15:0]      a_o,       // channel a data
  output logic [15:0]      b_o        // channel b data
);
  // quiet pins until the first data clock
  initial begin
    strobe_o = 1'b0;
    a_o = 16'h0000;
    b_o = 16'h0000;
  end
  // launch on the fall so data is settled at the latching rise
  always @(negedge dclk_i) begin
    a_o <= a_val_i;
    b_o <= b_val_i;
    strobe_o <= stb_req_i;
  end
endmodule

// ==== test_iqm_top.sv ====
/*
  test_iqm_top: serial register tasks and mixer path checks.
  assumes: lock pin loops back to its sense input; pll pin low
  until the last step.
*/
`timescale 1ns/1ps
`include "iqm_defines.svh"
module test_iqm_top;
  logic        clk, rstn, sck, sen_n, sdi, req, sdo, oe, dclk, ext, stb;
  logic [15:0] av, bv, ca, cb, da, db;         // samples in and out
  logic [15:0] qa [4], qb [4];                 // captured outputs
  logic [3:0]  csa, csb;                       // coarse steps
  logic [7:0]  fta, ftb, rv;                   // trims, read byte
  logic        pv, ov, pll;                    // last dclk, oe, pll pin
  int          n_errors, checks, n;            // counters
  iqm_top u_dut (.core_clk_i(clk), .rstn_i(rstn), .sif_clk_i(sck),
    .sif_en_n_i(sen_n), .sif_dio_i(sdi), .sif_dout_o(sdo),
    .sif_dout_oe_o(oe), .pll_supply_pin_i(pll),
    .lock_pin_sense_i(dclk), .phase_strobe_i(stb), .chan_a_i(ca),
    .chan_b_i(cb), .data_rate_clk_o(dclk), .ext_clk_mode_o(ext),
    .dac_a_o(da), .dac_b_o(db), .coarse_current_step_a_o(csa),
    .fine_current_trim_a_o(fta), .coarse_current_step_b_o(csb),
    .fine_current_trim_b_o(ftb));
  iqm_src_model u_src (.dclk_i(dclk), .stb_req_i(req), .a_val_i(av),
    .b_val_i(bv), .strobe_o(stb), .a_o(ca), .b_o(cb));
  // 25 mhz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // within two codes, for lookup rounding
  task automatic near(input string nm, input logic [15:0] v, e);
    chk(nm, 16'(16'(v - e + 16'h0002) <= 16'h0004), 16'h0001);
  endtask
  // one serial byte, msb first, 6 core cycles per clock half
  task automatic sbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sdi = v[i];
      sck = 1'b0;
      repeat (6) @(negedge clk);
      rv[i] = sdo;
      ov = oe;
      sck = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
  // one-byte frames; enable raised between frames
  task automatic frame(input logic [7:0] ins, d);
    sen_n = 1'b0;
    sbyte(ins);
    sbyte(d);
    repeat (6) @(negedge clk);
    sen_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // set mixer config, let the path settle, grab four samples
  task automatic mix(input logic [7:0] m);
    frame({3'b000, `IQM_A_MIX}, m);
    repeat (40) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      qa[i] = da;
      qb[i] = db;
    end
  endtask
  // set the rate field and count data-clock rises over 80 cycles
  task automatic rises(input logic [7:0] rate, input logic [15:0] e);
    frame({3'b000, `IQM_A_RATE}, rate);
    n = 0;
    pv = dclk;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      n += int'(dclk && !pv);
      pv = dclk;
    end
    chk("dclk rises", 16'(n), e);
  endtask
  // verdict and end of run
  task automatic conclude;
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #2000000;
    n_errors++;
    conclude;
  end
  // main sequence
  initial begin
    n_errors = 0;
    checks = 0;
    rstn = 1'b0;
    {sck, sen_n, sdi, req} = 4'b1100;
    pll = 1'b0;
    av = 16'h0100;
    bv = 16'h0030;
    repeat (2) @(negedge clk);
    chk("reset dac", da, 16'h0000);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk("ext mode", 16'(ext), 16'h0001);
    req = 1'b1;
    repeat (8) @(negedge clk);
    req = 1'b0;
    frame({3'b000, `IQM_A_TUNE0}, 8'ha5);
    frame({3'b100, `IQM_A_TUNE0}, 8'h00);
    chk("tune byte", 16'(rv), 16'h00a5);
    chk("read oe", 16'(ov), 16'h0001);
    chk("oe idle", 16'(oe), 16'h0000);
    frame({3'b000, `IQM_A_FSA1}, 8'h0f);
    frame({3'b000, `IQM_A_FSA0}, 8'h80);
    frame({3'b000, `IQM_A_FSB1}, 8'h03);
    frame({3'b000, `IQM_A_FSB0}, 8'h7f);
    chk("step a", 16'(csa), 16'h000f);
    chk("trim a", 16'(fta), 16'h0080);
    chk("step b", 16'(csb), 16'h0003);
    chk("trim b", 16'(ftb), 16'h007f);
    mix(8'h02);
    chk("pass a", qa[0], av);
    chk("pass b", qb[0], bv);
    mix(8'h06);
    chk("half a", qa[1], -qa[0]);
    chk("half ab", qb[0], (qa[0] === av) ? -bv : bv);
    mix(8'h08);
    chk("quarter a", qa[2], -qa[0]);
    chk("quarter ab", qa[1], -qb[0]);
    mix(8'h0e);
    chk("neg quarter", qa[1], -qb[0]);
    chk("neg quarter b", qb[1], qa[0]);
    mix(8'h50);
    near("fine a", da, av);
    near("fine b", db, bv);
    mix(8'h10);
    near("halved a", da, 16'h0080);
    frame({3'b000, `IQM_A_GA1}, 8'h05);
    frame({3'b000, `IQM_A_GA0}, 8'ha6);
    near("restored a", da, 16'h00b3);
    frame({3'b000, `IQM_A_GA1}, 8'h04);
    frame({3'b000, `IQM_A_GA0}, 8'h00);
    frame({3'b000, `IQM_A_PHS1}, 8'h40);
    mix(8'h50);
    near("rot a", da, -bv);
    near("rot b", db, av);
    frame({3'b000, `IQM_A_OA1}, 8'h1f);
    frame({3'b000, `IQM_A_OA0}, 8'hf0);
    mix(8'h00);
    chk("offset a", da, av - 16'h0010);
    rises(8'h03, 16'h000a);
    rises(8'h01, 16'h0014);
    pll = 1'b1;
    repeat (8) @(negedge clk);
    chk("pll mode", 16'(ext), 16'h0000);
    chk("dclk idle", 16'(dclk), 16'h0000);
    conclude;
  end
endmodule
